// ===== bench/dtc_pin_model.sv
// far-side model of the count pins of both units
// assumes the design drives a pin only while its active-low enable is low
`timescale 1ns/1ns
module dtc_pin_model (
  input wire logic clock,
  input wire logic out_a,
  input wire logic oe_n_a,
  input wire logic out_b,
  input wire logic oe_n_b,
  output logic pin_a,
  output logic pin_b
);
  logic [1:0] drv = 2'b11;

  // ==========================================================
  // wire level
  // pull-up: a released pin reads high unless falls drives it low, never a stale level
  assign pin_a = oe_n_a ? drv[0] : out_a;
  assign pin_b = oe_n_b ? drv[1] : out_b;

  // ==========================================================
  // falling edges for the counter function
  // eight clocks per level keeps the edge rate at clock/16
  task automatic falls(input logic sel, input int n);
    repeat (n) begin
      drv[sel] <= 1'b0;
      repeat (8) @(posedge clock);
      drv[sel] <= 1'b1;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule

// ===== bench/dtc_timer_tb.sv
// self-checking bench for the dual timer/counter
// assumes the pin model beside it; counting checked over stop/start windows
`timescale 1ns/1ns
module dtc_timer_tb;
  typedef struct {
    logic u;
    logic [7:0] mode, ctrl, speed;
    logic gate_hi;
    logic [7:0] lo, hi;
    int n;
    logic [7:0] elo, ehi;
    logic [1:0] est;
    logic etog;
  } dtc_row_t;

  logic clock, rst, clk_en, irq_ff, ext_irq_pin_a, ext_irq_pin_b;
  logic out_a, oe_n_a, out_b, oe_n_b, pin_a, pin_b;
  dtc_pkg::dtc_bus_req_t bus_req;
  logic [7:0] rd_data_ff;
  int errors = 0;
  int checked = 0;

  // ==========================================================
  // cases: unit, mode, ctrl, speed, gate pin, lo, hi, clocks, results
  dtc_row_t rows [13] = '{
    '{0, 8'h01, 8'h10, 8'h01, 1, 8'hFF, 8'hFF, 8, 8'h01, 8'h00, 2'b01, 1},
    '{0, 8'h01, 8'h10, 8'h00, 1, 8'hFE, 8'h00, 48, 8'h02, 8'h01, 2'b00, 0},
    '{0, 8'h00, 8'h10, 8'h01, 1, 8'hFF, 8'hFF, 8, 8'hE1, 8'h00, 2'b01, 1},
    '{0, 8'h00, 8'h10, 8'h01, 1, 8'h1F, 8'h00, 4, 8'h00, 8'h01, 2'b00, 0},
    '{0, 8'h02, 8'h10, 8'h01, 1, 8'hFE, 8'hA0, 12, 8'hA1, 8'hA0, 2'b01, 1},
    '{0, 8'h09, 8'h10, 8'h01, 0, 8'h10, 8'h00, 16, 8'h10, 8'h00, 2'b00, 0},
    '{0, 8'h09, 8'h10, 8'h01, 1, 8'h10, 8'h00, 16, 8'h14, 8'h00, 2'b00, 0},
    '{0, 8'h33, 8'h10, 8'h01, 1, 8'hFF, 8'h10, 8, 8'h01, 8'h10, 2'b01, 1},
    '{0, 8'h33, 8'h40, 8'h01, 1, 8'h10, 8'hFF, 8, 8'h10, 8'h01, 2'b10, 0},
    '{1, 8'h10, 8'h40, 8'h02, 1, 8'hFF, 8'hFF, 8, 8'h01, 8'h00, 2'b10, 1},
    '{1, 8'h30, 8'h40, 8'h02, 1, 8'h55, 8'h66, 16, 8'h55, 8'h66, 2'b00, 0},
    '{1, 8'h13, 8'h00, 8'h02, 1, 8'hFF, 8'hFF, 6, 8'h01, 8'h00, 2'b00, 1},
    '{1, 8'h90, 8'h40, 8'h02, 0, 8'h55, 8'h66, 8, 8'h55, 8'h66, 2'b00, 0}
  };

  dtc_timer uut (
    .clock(clock), .rst(rst), .clk_en(clk_en), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .irq_ff(irq_ff), .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
    .count_pin_a_in(pin_a), .count_pin_b_in(pin_b), .count_pin_a_out_ff(out_a),
    .count_pin_a_oe_n_ff(oe_n_a), .count_pin_b_out_ff(out_b), .count_pin_b_oe_n_ff(oe_n_b)
  );

  dtc_pin_model pin_model (
    .clock(clock), .out_a(out_a), .oe_n_a(oe_n_a), .out_b(out_b), .oe_n_b(oe_n_b),
    .pin_a(pin_a), .pin_b(pin_b)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================================
  // bus and compare tasks
  // a write stays up until the next task call replaces it at the same edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
  endtask

  task automatic idle(input int k);
    bus_req <= '0;
    repeat (k) @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1 d = rd_data_ff;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // everything frozen by mode 33h with both run bits clear
  task automatic prep(input logic u, input logic [7:0] spd, lo, hi, port);
    wr(4'h2, spd);
    wr(4'h3, port);
    wr({2'b01, u, 1'b0}, lo);
    wr({2'b01, u, 1'b1}, hi);
    wr(4'h8, 8'h03);
  endtask

  // run bits held for exactly n clock edges
  task automatic window(input logic [7:0] mode, ctrl, input int n);
    wr(4'h0, mode);
    wr(4'h1, ctrl);
    idle(n - 1);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h33);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clock);
    errors++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic tog;
    rst = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    ext_irq_pin_a = 1'b1;
    ext_irq_pin_b = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk8(d, 8'h00);
    end
    chk1(oe_n_a, 1'b1);
    chk1(oe_n_b, 1'b1);
    chk1(irq_ff, 1'b0);
    wr(4'h0, 8'hA5);
    wr(4'hF, 8'hFF);
    rd(4'h0, d);
    chk8(d, 8'hA5);
    @(posedge clock);
    #1 chk8(rd_data_ff, 8'h00);
    rd(4'hF, d);
    chk8(d, 8'h00);
    wr(4'h0, 8'h33);
    $display("reset and register test done");
    for (int i = 0; i < 13; i++) begin
      ext_irq_pin_a <= rows[i].gate_hi;
      ext_irq_pin_b <= rows[i].gate_hi;
      prep(rows[i].u, rows[i].speed, rows[i].lo, rows[i].hi, 8'h03);
      tog = rows[i].u ? out_b : out_a;
      window(rows[i].mode, rows[i].ctrl, rows[i].n);
      rd({2'b01, rows[i].u, 1'b0}, d);
      chk8(d, rows[i].elo);
      rd({2'b01, rows[i].u, 1'b1}, d);
      chk8(d, rows[i].ehi);
      rd(4'h8, d);
      chk8(d, {6'h00, rows[i].est});
      chk1(tog ^ (rows[i].u ? out_b : out_a), rows[i].etog);
      $display("case %0d done", i);
    end
    for (int u = 0; u < 2; u++) begin
      prep(u[0], 8'h00, 8'h00, 8'h00, 8'h00);
      wr(4'h0, u ? 8'h50 : 8'h05);
      wr(4'h1, u ? 8'h40 : 8'h10);
      idle(1);
      pin_model.falls(u[0], 3);
      idle(16);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h33);
      rd({2'b01, u[0], 1'b0}, d);
      chk8(d, 8'h03);
    end
    $display("pin counting test done");
    prep(1'b0, 8'h01, 8'h00, 8'h00, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h10);
    idle(3);
    clk_en <= 1'b0;
    repeat (8) @(posedge clock);
    clk_en <= 1'b1;
    idle(4);
    wr(4'h1, 8'h00);
    rd(4'h4, d);
    chk8(d, 8'h02);
    $display("clock enable test done");
    prep(1'b0, 8'h01, 8'hFF, 8'hFF, 8'h00);
    wr(4'h9, 8'h01);
    window(8'h01, 8'h10, 8);
    idle(2);
    #1 chk1(irq_ff, 1'b1);
    wr(4'h9, 8'h00);
    idle(2);
    #1 chk1(irq_ff, 1'b0);
    wr(4'h9, 8'h01);
    wr(4'h8, 8'h01);
    idle(2);
    #1 chk1(irq_ff, 1'b0);
    rd(4'h8, d);
    chk8(d, 8'h00);
    $display("interrupt test done");
    wr(4'h0, 8'h5A);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(4'h0, d);
    chk8(d, 8'h00);
    rd(4'h4, d);
    chk8(d, 8'h00);
    $display("mid-run reset test done");
    idle(1);
    end_of_test();
  end
endmodule

// ===== hw/dtc_defines.svh
// constants for the dual timer/counter: offsets, fields, resets, timing
// assumes an 8-bit register port with a 4-bit word address
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ==========================================================
// register word addresses
`define DTC_ADDR_MODE 4'h0
`define DTC_ADDR_CTRL 4'h1
`define DTC_ADDR_SPEED 4'h2
`define DTC_ADDR_PORT 4'h3
`define DTC_ADDR_U0_LO 4'h4
`define DTC_ADDR_U0_HI 4'h5
`define DTC_ADDR_U1_LO 4'h6
`define DTC_ADDR_U1_HI 4'h7
`define DTC_ADDR_STATUS 4'h8
`define DTC_ADDR_MASK 4'h9

// ==========================================================
// field positions
`define DTC_MODE0_LSB 0
`define DTC_FN0_BIT 2
`define DTC_GATE0_BIT 3
`define DTC_MODE1_LSB 4
`define DTC_FN1_BIT 6
`define DTC_GATE1_BIT 7
`define DTC_RUN0_BIT 4
`define DTC_FLAG0_BIT 5
`define DTC_RUN1_BIT 6
`define DTC_FLAG1_BIT 7

// ==========================================================
// reset values and timing
`define DTC_RST_BYTE 8'h00
`define DTC_CLK_PER_MC 4
`define DTC_SLOW_MC 3
`define DTC_MAX_LATENCY_CLK (12 * `DTC_CLK_PER_MC)

`endif

// ===== hw/dtc_pkg.sv
// types shared by the dual timer/counter
// assumes nothing beyond the defines header
package dtc_pkg;
  // ==========================================================
  // machine cycle phases
  typedef enum logic [3:0] {
    DTC_C1 = 4'b0001,
    DTC_C2 = 4'b0010,
    DTC_C3 = 4'b0100,
    DTC_C4 = 4'b1000
  } dtc_phase_t;

  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_bus_req_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_step_t;
endpackage

// ===== hw/dtc_timer.sv
// dual timer/counter with register port and interrupt output
// assumes pins and bus synchronous to clock; bus strobes one cycle each
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "dtc_defines.svh"
module dtc_timer #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire dtc_pkg::dtc_bus_req_t bus_req,
  output logic [7:0] rd_data_ff,
  output logic irq_ff,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic count_pin_a_in,
  input wire logic count_pin_b_in,
  output logic count_pin_a_out_ff,
  output logic count_pin_a_oe_n_ff,
  output logic count_pin_b_out_ff,
  output logic count_pin_b_oe_n_ff
);
  // ==========================================================
  // elaboration check
  generate
    if (ADDR_W != 4 || DATA_W != 8) begin : g_bad_width
      $error("dtc_timer supports only 4-bit address and 8-bit data");
    end
  endgenerate

  // ==========================================================
  // state
  dtc_pkg::dtc_phase_t phase_ff;
  logic [1:0] pre_ff;
  logic [7:0] timer_mode_reg_ff;
  logic unit0_run_ff;
  logic unit1_run_ff;
  logic [1:0] clock_speed_reg_ff;
  logic [1:0] port_mode_reg_ff;
  logic [7:0] unit0_low_byte_ff;
  logic [7:0] unit0_high_byte_ff;
  logic [7:0] unit1_low_byte_ff;
  logic [7:0] unit1_high_byte_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic samp_a_ff;
  logic samp_b_ff;
  logic pend_a_ff;
  logic pend_b_ff;

  dtc_pkg::dtc_mode_t mode0;
  dtc_pkg::dtc_mode_t mode1;
  logic fn0, fn1, gate0, gate1;
  logic at_c3, at_c4;
  logic tick0, tick1;
  logic en0, en1, en0_hi;
  logic inc0_lo, inc0_hi, inc1;
  logic ovf0, ovf0_hi, ovf1;
  logic set0, set1;
  logic tog0, tog1;
  logic wr_hit;
  dtc_pkg::dtc_step_t nxt_u0;
  dtc_pkg::dtc_step_t nxt_u1;

  assign mode0 = dtc_pkg::dtc_mode_t'(timer_mode_reg_ff[`DTC_MODE0_LSB +: 2]);
  assign mode1 = dtc_pkg::dtc_mode_t'(timer_mode_reg_ff[`DTC_MODE1_LSB +: 2]);
  assign fn0 = timer_mode_reg_ff[`DTC_FN0_BIT];
  assign fn1 = timer_mode_reg_ff[`DTC_FN1_BIT];
  assign gate0 = timer_mode_reg_ff[`DTC_GATE0_BIT];
  assign gate1 = timer_mode_reg_ff[`DTC_GATE1_BIT];
  assign at_c3 = clk_en && (phase_ff == dtc_pkg::DTC_C3);
  assign at_c4 = clk_en && (phase_ff == dtc_pkg::DTC_C4);
  assign wr_hit = clk_en && bus_req.wr;

  // ==========================================================
  // machine cycle sequencer and prescale
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_ff <= dtc_pkg::DTC_C1;
    end else if (clk_en) begin
      unique case (phase_ff)
        dtc_pkg::DTC_C1: phase_ff <= dtc_pkg::DTC_C2;
        dtc_pkg::DTC_C2: phase_ff <= dtc_pkg::DTC_C3;
        dtc_pkg::DTC_C3: phase_ff <= dtc_pkg::DTC_C4;
        dtc_pkg::DTC_C4: phase_ff <= dtc_pkg::DTC_C1;
        default: phase_ff <= dtc_pkg::DTC_C1;
      endcase
    end
  end

  // machine cycles counted modulo three for the slow time base
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_ff <= 2'h0;
    end else if (at_c4) begin
      pre_ff <= (pre_ff == 2'(`DTC_SLOW_MC - 1)) ? 2'h0 : pre_ff + 2'h1;
    end
  end

  assign tick0 = at_c3 && (clock_speed_reg_ff[0] || pre_ff == 2'(`DTC_SLOW_MC - 1));
  assign tick1 = at_c3 && (clock_speed_reg_ff[1] || pre_ff == 2'(`DTC_SLOW_MC - 1));

  // ==========================================================
  // pin edge detection
  // edge found at C4, consumed at the next C3: three clocks of delay
  always_ff @(posedge clock) begin
    if (rst) begin
      samp_a_ff <= 1'b0;
      samp_b_ff <= 1'b0;
    end else if (at_c4) begin
      samp_a_ff <= count_pin_a_in;
      samp_b_ff <= count_pin_b_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_a_ff <= 1'b0;
      pend_b_ff <= 1'b0;
    end else if (at_c4) begin
      pend_a_ff <= samp_a_ff && !count_pin_a_in;
      pend_b_ff <= samp_b_ff && !count_pin_b_in;
    end else if (at_c3) begin
      pend_a_ff <= 1'b0;
      pend_b_ff <= 1'b0;
    end
  end

  // ==========================================================
  // count enables
  assign en0 = unit0_run_ff && (!gate0 || ext_irq_pin_a);
  assign en0_hi = unit1_run_ff;
  assign en1 = ((mode0 == dtc_pkg::DTC_MODE_SPLIT) || unit1_run_ff) && (!gate1 || ext_irq_pin_b);
  assign inc0_lo = en0 && (fn0 ? (at_c3 && pend_a_ff) : tick0);
  assign inc0_hi = en0_hi && tick0;
  assign inc1 = en1 && (mode1 != dtc_pkg::DTC_MODE_SPLIT) && (fn1 ? (at_c3 && pend_b_ff) : tick1);

  function automatic dtc_pkg::dtc_step_t step(input dtc_pkg::dtc_mode_t mode, input logic [7:0] hi,
                                              input logic [7:0] lo, input logic inc);
    dtc_pkg::dtc_step_t r;
    logic [12:0] v13;
    logic [15:0] v16;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    v13 = {hi, lo[4:0]} + 13'h0001;
    v16 = {hi, lo} + 16'h0001;
    if (inc) begin
      unique case (mode)
        dtc_pkg::DTC_MODE_13: begin
          r.ovf = (v13 == 13'h0000);
          r.hi = v13[12:5];
          r.lo = {lo[7:5], v13[4:0]};
        end
        dtc_pkg::DTC_MODE_16: begin
          r.ovf = (v16 == 16'h0000);
          r.hi = v16[15:8];
          r.lo = v16[7:0];
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          r.ovf = (lo == 8'hff);
          r.lo = (lo == 8'hff) ? hi : lo + 8'h01;
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  always_comb begin
    nxt_u0 = step(mode0, unit0_high_byte_ff, unit0_low_byte_ff, inc0_lo);
    ovf0_hi = 1'b0;
    if (mode0 == dtc_pkg::DTC_MODE_SPLIT) begin
      nxt_u0.ovf = inc0_lo && (unit0_low_byte_ff == 8'hff);
      nxt_u0.lo = inc0_lo ? unit0_low_byte_ff + 8'h01 : unit0_low_byte_ff;
      ovf0_hi = inc0_hi && (unit0_high_byte_ff == 8'hff);
      nxt_u0.hi = inc0_hi ? unit0_high_byte_ff + 8'h01 : unit0_high_byte_ff;
    end
    nxt_u1 = step(mode1, unit1_high_byte_ff, unit1_low_byte_ff, inc1);
  end

  assign ovf0 = nxt_u0.ovf;
  assign ovf1 = nxt_u1.ovf;
  assign set0 = ovf0;
  assign set1 = (mode0 == dtc_pkg::DTC_MODE_SPLIT) ? ovf0_hi : ovf1;
  assign tog0 = ovf0 && !fn0 && port_mode_reg_ff[0];
  assign tog1 = ovf1 && !fn1 && port_mode_reg_ff[1];

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_mode_reg_ff <= `DTC_RST_BYTE;
      unit0_run_ff <= 1'b0;
      unit1_run_ff <= 1'b0;
      clock_speed_reg_ff <= 2'h0;
      port_mode_reg_ff <= 2'h0;
      mask_ff <= 2'h0;
    end else if (wr_hit) begin
      if (bus_req.addr == `DTC_ADDR_MODE) begin
        timer_mode_reg_ff <= bus_req.wdata;
      end
      if (bus_req.addr == `DTC_ADDR_CTRL) begin
        unit0_run_ff <= bus_req.wdata[`DTC_RUN0_BIT];
        unit1_run_ff <= bus_req.wdata[`DTC_RUN1_BIT];
      end
      if (bus_req.addr == `DTC_ADDR_SPEED) begin
        clock_speed_reg_ff <= bus_req.wdata[1:0];
      end
      if (bus_req.addr == `DTC_ADDR_PORT) begin
        port_mode_reg_ff <= bus_req.wdata[1:0];
      end
      if (bus_req.addr == `DTC_ADDR_MASK) begin
        mask_ff <= bus_req.wdata[1:0];
      end
    end
  end

  // ==========================================================
  // count registers; a software write wins over the count in that cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      unit0_low_byte_ff <= `DTC_RST_BYTE;
      unit0_high_byte_ff <= `DTC_RST_BYTE;
      unit1_low_byte_ff <= `DTC_RST_BYTE;
      unit1_high_byte_ff <= `DTC_RST_BYTE;
    end else if (clk_en) begin
      unit0_low_byte_ff <= (bus_req.wr && bus_req.addr == `DTC_ADDR_U0_LO) ? bus_req.wdata : nxt_u0.lo;
      unit0_high_byte_ff <= (bus_req.wr && bus_req.addr == `DTC_ADDR_U0_HI) ? bus_req.wdata : nxt_u0.hi;
      unit1_low_byte_ff <= (bus_req.wr && bus_req.addr == `DTC_ADDR_U1_LO) ? bus_req.wdata : nxt_u1.lo;
      unit1_high_byte_ff <= (bus_req.wr && bus_req.addr == `DTC_ADDR_U1_HI) ? bus_req.wdata : nxt_u1.hi;
    end
  end

  // ==========================================================
  // overflow flags, write one to clear; a new overflow beats the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      status_ff <= 2'h0;
    end else if (clk_en) begin
      status_ff[0] <= set0 || (status_ff[0] && !(bus_req.wr && bus_req.addr == `DTC_ADDR_STATUS &&
                                                 bus_req.wdata[0]));
      status_ff[1] <= set1 || (status_ff[1] && !(bus_req.wr && bus_req.addr == `DTC_ADDR_STATUS &&
                                                 bus_req.wdata[1]));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ==========================================================
  // toggle outputs; pin driven only while its toggle enable is set
  always_ff @(posedge clock) begin
    if (rst) begin
      count_pin_a_out_ff <= 1'b0;
      count_pin_b_out_ff <= 1'b0;
      count_pin_a_oe_n_ff <= 1'b1;
      count_pin_b_oe_n_ff <= 1'b1;
    end else if (clk_en) begin
      count_pin_a_out_ff <= count_pin_a_out_ff ^ tog0;
      count_pin_b_out_ff <= count_pin_b_out_ff ^ tog1;
      count_pin_a_oe_n_ff <= !port_mode_reg_ff[0];
      count_pin_b_oe_n_ff <= !port_mode_reg_ff[1];
    end
  end

  // ==========================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (clk_en) begin
      rd_data_ff <= 8'h00;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          `DTC_ADDR_MODE: rd_data_ff <= timer_mode_reg_ff;
          `DTC_ADDR_CTRL: rd_data_ff <= {status_ff[1], unit1_run_ff, status_ff[0], unit0_run_ff, 4'h0};
          `DTC_ADDR_SPEED: rd_data_ff <= {6'h00, clock_speed_reg_ff};
          `DTC_ADDR_PORT: rd_data_ff <= {6'h00, port_mode_reg_ff};
          `DTC_ADDR_U0_LO: rd_data_ff <= unit0_low_byte_ff;
          `DTC_ADDR_U0_HI: rd_data_ff <= unit0_high_byte_ff;
          `DTC_ADDR_U1_LO: rd_data_ff <= unit1_low_byte_ff;
          `DTC_ADDR_U1_HI: rd_data_ff <= unit1_high_byte_ff;
          `DTC_ADDR_STATUS: rd_data_ff <= {6'h00, status_ff};
          `DTC_ADDR_MASK: rd_data_ff <= {6'h00, mask_ff};
          default: rd_data_ff <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  sequence s_u0_wr;
    clk_en && bus_req.wr && bus_req.addr == `DTC_ADDR_U0_LO;
  endsequence
  sequence s_hi_wrap;
    clk_en && mode0 == dtc_pkg::DTC_MODE_SPLIT && inc0_hi && unit0_high_byte_ff == 8'hff && !bus_req.wr;
  endsequence
  sequence s_reload;
    clk_en && mode0 == dtc_pkg::DTC_MODE_RELOAD && inc0_lo && unit0_low_byte_ff == 8'hff && !bus_req.wr;
  endsequence

  property p_phase_onehot;
    @(posedge clock) disable iff (rst) $onehot(phase_ff);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");

  property p_phase_wrap;
    @(posedge clock) disable iff (rst) (phase_ff == dtc_pkg::DTC_C4 && clk_en) |=> phase_ff == dtc_pkg::DTC_C1;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("machine cycle not four clocks");

  property p_slow_tick;
    @(posedge clock) disable iff (rst) tick0 |-> (clock_speed_reg_ff[0] || pre_ff == 2'h2);
  endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("tick outside prescale slot");

  property p_sample_c4;
    @(posedge clock) disable iff (rst) !$past(rst) && !$stable(samp_a_ff) |-> $past(at_c4);
  endproperty
  a_sample_c4: assert property (p_sample_c4) else $error("pin sampled outside C4");

  property p_count_c3;
    @(posedge clock) disable iff (rst)
      !$past(rst) && !$stable(unit0_low_byte_ff) |-> $past(at_c3) || $past(bus_req.wr);
  endproperty
  a_count_c3: assert property (p_count_c3) else $error("count changed outside C3");

  property p_run_off;
    @(posedge clock) disable iff (rst)
      (clk_en && !unit0_run_ff && mode0 != dtc_pkg::DTC_MODE_SPLIT && !bus_req.wr)
      |=> $stable(unit0_low_byte_ff) && $stable(unit0_high_byte_ff);
  endproperty
  a_run_off: assert property (p_run_off) else $error("unit 0 counted while stopped");

  property p_mode0_upper;
    @(posedge clock) disable iff (rst)
      (clk_en && mode0 == dtc_pkg::DTC_MODE_13 && !bus_req.wr) |=> $stable(unit0_low_byte_ff[7:5]);
  endproperty
  a_mode0_upper: assert property (p_mode0_upper) else $error("upper low-byte bits counted");

  property p_reload;
    @(posedge clock) disable iff (rst) s_reload |=> unit0_low_byte_ff == $past(unit0_high_byte_ff) && status_ff[0];
  endproperty
  a_reload: assert property (p_reload) else $error("auto reload failed");

  property p_unit1_hold;
    @(posedge clock) disable iff (rst)
      (clk_en && mode1 == dtc_pkg::DTC_MODE_SPLIT && !bus_req.wr) |=> $stable(unit1_low_byte_ff);
  endproperty
  a_unit1_hold: assert property (p_unit1_hold) else $error("unit 1 counted in mode 3");

  property p_toggle;
    @(posedge clock) disable iff (rst) tog0 |=> count_pin_a_out_ff != $past(count_pin_a_out_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle output missed overflow");

  property p_u0_write;
    @(posedge clock) disable iff (rst) s_u0_wr |=> unit0_low_byte_ff == $past(bus_req.wdata);
  endproperty
  a_u0_write: assert property (p_u0_write) else $error("count byte write lost");

  property p_split_hi;
    @(posedge clock) disable iff (rst) s_hi_wrap |=> unit0_high_byte_ff == 8'h00 && status_ff[1];
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high byte overflow missed");

  property p_split_no_flag;
    @(posedge clock) disable iff (rst)
      (clk_en && mode0 == dtc_pkg::DTC_MODE_SPLIT && !ovf0_hi && !bus_req.wr)
      |=> status_ff[1] == $past(status_ff[1]);
  endproperty
  a_split_no_flag: assert property (p_split_no_flag) else $error("unit 1 flag moved in split mode");

  property p_oe_follow;
    @(posedge clock) disable iff (rst) clk_en |=> count_pin_a_oe_n_ff == !$past(port_mode_reg_ff[0]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable not following toggle enable");
endmodule
